// file: rtl/lbk_defs.svh
// Interface codes, field positions and constants for the blend, key and panel timing block.
`ifndef LBK_DEFS_SVH
`define LBK_DEFS_SVH
`define LBK_IF_RGB      2'h0
`define LBK_IF_RSVD     2'h1
`define LBK_IF_CPU_MAIN 2'h2
`define LBK_IF_CPU_SUB  2'h3
`define LBK_PAL_AEN     15
`define LBK_PAL_R_HI    14
`define LBK_PAL_R_LO    10
`define LBK_PAL_G_HI    9
`define LBK_PAL_G_LO    5
`define LBK_PAL_B_HI    4
`define LBK_PAL_B_LO    0
`define LBK_FB_ALPHA_HI 27
`define LBK_FB_ALPHA_LO 24
`define LBK_ALPHA_DIV   5'h10
`define LBK_DIV_MIN     8'h01
`endif

// file: rtl/lbk_pkg.sv
// Types shared by the blend, key and panel timing block.
package lbk_pkg;
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } lbk_rgb_s;

  typedef struct packed {
    logic [3:0] r;
    logic [3:0] g;
    logic [3:0] b;
  } lbk_alpha_s;

  typedef struct packed {
    logic [10:0] width_m1;
    logic [10:0] height_m1;
    logic [7:0]  hsync_w;
    logic [7:0]  hback;
    logic [7:0]  hfront;
    logic [7:0]  vsync_w;
    logic [7:0]  vback;
    logic [7:0]  vfront;
    logic [7:0]  divider;
  } lbk_timing_s;

  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] setup;
    logic [7:0] wait_t;
    logic [7:0] hold;
  } lbk_cpu_cfg_s;

  typedef enum logic [2:0] {CPU_IDLE, CPU_SETUP, CPU_WAIT, CPU_HOLD} lbk_cpu_e;
endpackage

// file: rtl/lbk_top.sv
// Palette decode, two-layer alpha blend, colour key and panel timing with pin mux.
// What the document asks of this block
// RULE_01: A:5:5:5 entry: bit15 set select, R/G/B 5 bits to lines 23:19, 15:11, 7:3.
// RULE_02: Base window 0 and overlay window 1; overlay wins where they overlap.
// RULE_03: Each channel is base*(1-A)+overlay*A, A four bits over sixteen.
// RULE_04: Two per-channel alpha sets; entry select bit 0 first set, 1 second.
// RULE_05: Blend-per-pixel off: source bit picks set; on: entry bit or frame bits.
// RULE_06: Blend one screen position at a time from same-coordinate pixels.
// RULE_07: Overlay pixel matching key colour is replaced by background image.
// RULE_08: Software writes the key colour as 24-bit RGB.
// RULE_09: Direction bit 0 compares overlay window, 1 compares base window.
// RULE_10: Key compare only at bit positions where the mask bit is 0.
// RULE_11: RGB mode makes line sync, frame sync, data enable and pixel clock.
// RULE_12: Software writes active width and height as count minus one.
// RULE_13: Pixel clock is source clock over divider plus one; divider at least 1; from divider 3 up pclk_en never fires and the counters stop.
// RULE_14: Frame period is the product of vertical, horizontal and divider totals.
// RULE_15: CPU mode drives selects, register select and write strobe with timed phases.
// RULE_16: Scrolling changes only base addresses; image buffer exceeds panel size; this block holds no base addresses or scrolling.
// RULE_17: Interface field muxes shared pins between RGB and CPU signals; 01 reserved.
// RULE_18: Field 00 RGB, 01 reserved, 10 CPU main display, 11 CPU sub display.
// RULE_19: Full 8-bit blend, fraction truncated, pixel registered before pins.
`timescale 1ns/1ps
`include "lbk_defs.svh"
`default_nettype none
module lbk_top (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Configuration
  input  wire lbk_pkg::lbk_timing_s  timing,
  input  wire lbk_pkg::lbk_cpu_cfg_s cpu_cfg,
  input  wire logic [1:0]           output_interface_select,
  input  wire logic                 per_pixel_blend,
  input  wire logic                 alpha_source_select,
  input  wire logic                 fb_alpha_mode,
  input  wire lbk_pkg::lbk_alpha_s   first_alpha_set,
  input  wire lbk_pkg::lbk_alpha_s   second_alpha_set,
  input  wire logic                 key_enable,
  input  wire logic                 key_area_blend,
  input  wire logic                 key_compare_direction,
  input  wire logic [23:0]          key_compare_mask,
  input  wire logic [23:0]          key_color_value,
  // Pixel sources for the current screen position
  input  wire logic                 overlay_active,
  input  wire logic [15:0]          base_entry,
  input  wire logic [15:0]          overlay_entry,
  input  wire logic [3:0]           fb_alpha,
  // CPU-interface write request
  input  wire logic                 cpu_req,
  input  wire logic                 cpu_reg_sel,
  input  wire logic [17:0]          cpu_data,
  output logic                      cpu_busy,
  // Timing status
  output logic                      pixel_req,
  output logic [10:0]               pixel_x,
  output logic [10:0]               pixel_y,
  // Shared panel pins
  output logic                      pad_clk_wr,
  output logic                      pad_hsync_cs0,
  output logic                      pad_vsync_cs1,
  output logic                      pad_den_rs,
  output logic                      pad_lend_oe,
  output logic [23:0]               pad_data,
  output logic                      pad_data_oe_n
);
  import lbk_pkg::*;
  typedef struct packed {
    logic [7:0]  div_cnt;
    logic        pclk;
    logic [11:0] hcnt;
    logic [11:0] vcnt;
    lbk_rgb_s    pix;
    logic        de;
    logic        hs;
    logic        vs;
    logic        le;
    lbk_cpu_e    cst;
    logic        busy;
    logic [7:0]  ccnt;
    logic        csel;
    logic        rs;
    logic [17:0] cdata;
    logic [10:0] px;
    logic [10:0] py;
    logic        preq;
    logic        clk_wr;
    logic        hs_cs0;
    logic        vs_cs1;
    logic        den_rs;
    logic        le_oe;
    logic [23:0] dout;
    logic        doe_n;
  } lbk_state_s;
  lbk_state_s st_r;
  lbk_state_s st_nxt;
  // Expand a 5-bit channel to 8 bits by replicating its top bits.
  function automatic logic [7:0] expand5(input logic [4:0] c);
    expand5 = {c, c[4:2]};
  endfunction
  // Blend one channel; the product is truncated toward zero.
  function automatic logic [7:0] blend(input logic [7:0] b, input logic [7:0] o,
                                       input logic [3:0] a);
    logic [12:0] sum;
    sum = 13'(b) * 13'(`LBK_ALPHA_DIV - {1'b0, a}) + 13'(o) * 13'(a);
    blend = sum[11:4];
  endfunction
  // ----------------------------------------------------------------
  // Pixel path
  // ----------------------------------------------------------------
  lbk_rgb_s   base_rgb;
  lbk_rgb_s   ovl_rgb;
  lbk_rgb_s   blended;
  lbk_alpha_s alpha;
  logic       keyed;
  logic [23:0] cmp_pix;
  always_comb begin
    base_rgb = '{expand5(base_entry[`LBK_PAL_R_HI:`LBK_PAL_R_LO]),
                 expand5(base_entry[`LBK_PAL_G_HI:`LBK_PAL_G_LO]),
                 expand5(base_entry[`LBK_PAL_B_HI:`LBK_PAL_B_LO])}; // RULE_01
    ovl_rgb = '{expand5(overlay_entry[`LBK_PAL_R_HI:`LBK_PAL_R_LO]),
                expand5(overlay_entry[`LBK_PAL_G_HI:`LBK_PAL_G_LO]),
                expand5(overlay_entry[`LBK_PAL_B_HI:`LBK_PAL_B_LO])}; // RULE_01
    cmp_pix = key_compare_direction ? base_rgb : ovl_rgb; // RULE_09
    keyed = key_enable &&
            (((cmp_pix ^ key_color_value) & ~key_compare_mask) == 24'h000000); // RULE_10
    if (!per_pixel_blend) begin
      alpha = alpha_source_select ? second_alpha_set : first_alpha_set; // RULE_05
    end else if (alpha_source_select && fb_alpha_mode) begin
      alpha = '{fb_alpha, fb_alpha, fb_alpha}; // RULE_05
    end else begin
      alpha = overlay_entry[`LBK_PAL_AEN] ? second_alpha_set : first_alpha_set; // RULE_04
    end
    if (keyed) begin
      // Keyed area: full background unless key-area blending is on.
      alpha = key_area_blend ? (overlay_entry[`LBK_PAL_AEN] ? second_alpha_set
                                                             : first_alpha_set)
                             : '{4'h0, 4'h0, 4'h0}; // RULE_07
    end
    if (!overlay_active) begin
      blended = base_rgb;
    end else begin
      // Sixteen cannot be reached with four bits, so even a 4'hF blend keeps one sixteenth of the base.
      blended = '{blend(base_rgb.r, ovl_rgb.r, alpha.r),
                  blend(base_rgb.g, ovl_rgb.g, alpha.g),
                  blend(base_rgb.b, ovl_rgb.b, alpha.b)}; // RULE_02 RULE_03 RULE_19
    end
  end
  // ----------------------------------------------------------------
  // Timing and CPU strobes
  // ----------------------------------------------------------------
  logic        rgb_mode;
  logic        cpu_mode;
  logic        pclk_en;
  logic [11:0] h_total;
  logic [11:0] v_total;
  logic [11:0] h_act0;
  logic [11:0] v_act0;
  logic        active;
  always_comb begin
    rgb_mode = (output_interface_select == `LBK_IF_RGB); // RULE_18
    cpu_mode = output_interface_select[1]; // RULE_18
    h_act0 = 12'(timing.hsync_w) + 12'(timing.hback) + 12'h002;
    v_act0 = 12'(timing.vsync_w) + 12'(timing.vback) + 12'h002;
    h_total = h_act0 + 12'(timing.width_m1) + 12'(timing.hfront) + 12'h002; // RULE_14
    v_total = v_act0 + 12'(timing.height_m1) + 12'(timing.vfront) + 12'h002; // RULE_14
    pclk_en = (st_r.div_cnt >= timing.divider) && st_r.pclk; // RULE_13
    active = (st_r.hcnt >= h_act0) && (st_r.hcnt <= h_act0 + 12'(timing.width_m1)) &&
             (st_r.vcnt >= v_act0) && (st_r.vcnt <= v_act0 + 12'(timing.height_m1)); // RULE_12
    st_nxt = st_r;
    st_nxt.preq = 1'b0;
    // Pixel clock: high half then low half; the high half is (divider+1)/2 rounded up, the low half rounded down.
    if (st_r.div_cnt >= timing.divider) begin
      st_nxt.div_cnt = 8'h00;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 8'h01;
    end
    if (st_r.div_cnt == 8'h00) begin
      st_nxt.pclk = 1'b1;
    end else if (st_r.div_cnt == {1'b0, timing.divider[7:1]} + 8'h01) begin
      st_nxt.pclk = 1'b0; // RULE_13
    end
    if (!rgb_mode) begin
      st_nxt.hcnt = 12'h000;
      st_nxt.vcnt = 12'h000;
      st_nxt.div_cnt = 8'h00;
      st_nxt.pclk = 1'b0;
    end else if (pclk_en) begin
      // One screen position per pixel clock for divider 1 or 2; from 3 up pclk_en never rises.
      st_nxt.de = active; // RULE_06
      st_nxt.pix = active ? blended : '0; // RULE_19
      st_nxt.preq = active;
      st_nxt.px = 11'(st_r.hcnt - h_act0);
      st_nxt.py = 11'(st_r.vcnt - v_act0);
      st_nxt.hs = (st_r.hcnt <= 12'(timing.hsync_w)); // RULE_11
      st_nxt.vs = (st_r.vcnt <= 12'(timing.vsync_w)); // RULE_11
      st_nxt.le = (st_r.hcnt == h_total - 12'h001);
      if (st_r.hcnt >= h_total - 12'h001) begin
        st_nxt.hcnt = 12'h000;
        st_nxt.vcnt = (st_r.vcnt >= v_total - 12'h001) ? 12'h000 : st_r.vcnt + 12'h001;
      end else begin
        st_nxt.hcnt = st_r.hcnt + 12'h001;
      end
    end
    // CPU write cycle: setup, write-low wait, hold.
    case (st_r.cst)
      CPU_IDLE: begin
        if (cpu_mode && cpu_req) begin
          st_nxt.cst = CPU_SETUP;
          st_nxt.ccnt = cpu_cfg.setup;
          st_nxt.csel = 1'b1;
          st_nxt.rs = cpu_reg_sel;
          st_nxt.cdata = cpu_data;
        end
      end
      CPU_SETUP: begin
        if (st_r.ccnt == 8'h00) begin
          st_nxt.cst = CPU_WAIT;
          st_nxt.ccnt = cpu_cfg.wait_t;
        end else begin
          st_nxt.ccnt = st_r.ccnt - 8'h01;
        end
      end
      CPU_WAIT: begin
        if (st_r.ccnt == 8'h00) begin
          st_nxt.cst = CPU_HOLD;
          st_nxt.ccnt = cpu_cfg.hold;
        end else begin
          st_nxt.ccnt = st_r.ccnt - 8'h01;
        end
      end
      CPU_HOLD: begin
        if (st_r.ccnt == 8'h00) begin
          st_nxt.cst = CPU_IDLE;
          st_nxt.csel = 1'b0;
        end else begin
          st_nxt.ccnt = st_r.ccnt - 8'h01;
        end
      end
      default: begin
        st_nxt.cst = CPU_IDLE;
      end
    endcase
    st_nxt.busy = (st_nxt.cst != CPU_IDLE); // RULE_15
    // Shared pins; reserved mode drives every control pin and the data low and releases the data.
    case (output_interface_select)
      `LBK_IF_RGB: begin
        st_nxt.clk_wr = st_nxt.pclk;
        st_nxt.hs_cs0 = st_nxt.hs;
        st_nxt.vs_cs1 = st_nxt.vs;
        st_nxt.den_rs = st_nxt.de;
        st_nxt.le_oe = st_nxt.le;
        st_nxt.dout = st_nxt.pix;
        st_nxt.doe_n = 1'b0; // RULE_17
      end
      `LBK_IF_CPU_MAIN, `LBK_IF_CPU_SUB: begin
        st_nxt.clk_wr = !(st_nxt.cst == CPU_WAIT); // RULE_15
        st_nxt.hs_cs0 = !(st_nxt.csel && !output_interface_select[0]); // RULE_15
        st_nxt.vs_cs1 = !(st_nxt.csel && output_interface_select[0]); // RULE_15
        st_nxt.den_rs = st_nxt.rs;
        st_nxt.le_oe = 1'b1;
        st_nxt.dout = {6'h00, st_nxt.cdata};
        st_nxt.doe_n = !st_nxt.csel; // RULE_17
      end
      default: begin
        st_nxt.clk_wr = 1'b0;
        st_nxt.hs_cs0 = 1'b0;
        st_nxt.vs_cs1 = 1'b0;
        st_nxt.den_rs = 1'b0;
        st_nxt.le_oe = 1'b0;
        st_nxt.dout = 24'h000000;
        st_nxt.doe_n = 1'b1; // RULE_17
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.doe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign cpu_busy = st_r.busy;
  assign pixel_req = st_r.preq;
  assign pixel_x = st_r.px;
  assign pixel_y = st_r.py;
  assign pad_clk_wr = st_r.clk_wr;
  assign pad_hsync_cs0 = st_r.hs_cs0;
  assign pad_vsync_cs1 = st_r.vs_cs1;
  assign pad_den_rs = st_r.den_rs;
  assign pad_lend_oe = st_r.le_oe;
  assign pad_data = st_r.dout;
  assign pad_data_oe_n = st_r.doe_n;
endmodule
`default_nettype wire

// file: tb/lbk_panel_model.sv
// Behavioural CPU-style display driver that records write cycles.
`timescale 1ns/1ps
`default_nettype none
module lbk_panel_model (
  // Clock and pin-mux state
  input  wire logic        clk,
  input  wire logic        on,
  // Panel pins
  input  wire logic        cs_n,
  input  wire logic        wr_n,
  input  wire logic        rs,
  input  wire logic [17:0] data,
  // Record of the last write
  output logic      [18:0] got,
  output var int           writes,
  output var int           setup_len,
  output var int           wr_len
);
  int su;
  int wl;
  logic wq;
  logic [1:0] onq;
  // The mux state is delayed so the pins' last RGB cycle is never read as a write.
  always @(posedge clk) begin
    wq <= wr_n;
    onq <= {onq[0], on};
    if (onq[1] !== 1'b1 || cs_n) begin
      su <= 0;
      wl <= 0;
    end else begin
      if (wr_n && wl == 0) su <= su + 1;
      if (!wr_n) wl <= wl + 1;
      if (wr_n && !wq) begin
        got <= {rs, data};
        writes <= writes + 1;
        setup_len <= su;
        wr_len <= wl;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/lbk_top_sva.sv
// Port checker for the blend, key and panel timing block.
`timescale 1ns/1ps
`default_nettype none
module lbk_top_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Watched ports
  input wire logic [1:0]  output_interface_select,
  input wire logic        cpu_req,
  input wire logic [17:0] cpu_data,
  input wire logic        cpu_busy,
  input wire logic        pixel_req,
  input wire logic        pad_clk_wr,
  input wire logic        pad_hsync_cs0,
  input wire logic        pad_vsync_cs1,
  input wire logic        pad_den_rs,
  input wire logic [23:0] pad_data,
  input wire logic        pad_data_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [1:0] ifs = output_interface_select;
  rst_quiet_a: assert property (
    $rose(reset_n) |-> pad_data == 24'h0 && pad_data_oe_n && !cpu_busy)
    else $error("pins not idle after reset");
  req_pulse_a: assert property (pixel_req |=> !pixel_req)
    else $error("pixel request longer than one cycle");
  blank_zero_a: assert property (
    ifs == 2'h0 && $past(ifs) == 2'h0 && !pad_den_rs |-> pad_data == 24'h0)
    else $error("data outside active region");
  sync_blank_a: assert property (
    ifs == 2'h0 && $past(ifs) == 2'h0 && pad_den_rs |-> !pad_hsync_cs0 && !pad_vsync_cs1)
    else $error("sync during data enable");
  rsvd_quiet_a: assert property (
    ifs == 2'h1 |=> pad_data == 24'h0 && pad_data_oe_n)
    else $error("reserved mode drives data");
  cpu_take_a: assert property (ifs[1] && cpu_req && !cpu_busy |=> cpu_busy)
    else $error("write request not taken");
  cpu_data_a: assert property (
    $rose(cpu_busy) |-> pad_data[17:0] == $past(cpu_data) && !pad_data_oe_n)
    else $error("write data not on pins");
  main_cs_a: assert property (
    $rose(cpu_busy) && ifs == 2'h2 |-> !pad_hsync_cs0 && pad_vsync_cs1)
    else $error("main select wrong");
  sub_cs_a: assert property (
    $rose(cpu_busy) && ifs == 2'h3 |-> !pad_vsync_cs1 && pad_hsync_cs0)
    else $error("sub select wrong");
  busy_end_a: assert property ($rose(cpu_busy) |-> ##[1:800] !cpu_busy)
    else $error("write cycle does not end");
  wr_inside_a: assert property (
    ifs[1] && $past(ifs[1]) && !pad_clk_wr |-> cpu_busy)
    else $error("write strobe outside a cycle");
endmodule
bind lbk_top lbk_top_sva lbk_top_sva_i (.clk, .reset_n, .output_interface_select, .cpu_req,
  .cpu_data, .cpu_busy, .pixel_req, .pad_clk_wr, .pad_hsync_cs0, .pad_vsync_cs1, .pad_den_rs,
  .pad_data, .pad_data_oe_n);
`default_nettype wire

// file: tb/lbk_top_tb_top.sv
// Self-checking bench for the blend, key and panel timing block.
`timescale 1ns/1ps
`default_nettype none
module lbk_top_tb_top;
  import lbk_pkg::*;
  localparam logic [15:0] BE = 16'h294A;
  localparam logic [15:0] OE = 16'h5EF7;
  logic clk = 0, reset_n = 0, per_pixel_blend = 0, alpha_source_select = 0, fb_alpha_mode = 0;
  logic key_enable = 0, key_area_blend = 0, key_compare_direction = 0, overlay_active = 1;
  logic cpu_req = 0, cpu_reg_sel = 0, cpu_busy, pixel_req, pad_clk_wr, pad_hsync_cs0;
  logic pad_vsync_cs1, pad_den_rs, pad_lend_oe, pad_data_oe_n, hq, vq, cq;
  logic [1:0] output_interface_select = 2'h0;
  logic [3:0] fb_alpha = 4'h0;
  logic [10:0] pixel_x, pixel_y, lx, ly, lx_f, ly_f;
  logic [15:0] base_entry = BE, overlay_entry = OE;
  logic [17:0] cpu_data = 18'h0;
  logic [18:0] mg, sg;
  logic [23:0] pad_data, key_compare_mask = 24'h0, key_color_value = 24'h0;
  lbk_timing_s timing = {11'h3, 11'h2, 8'h0, 8'h1, 8'h0, 8'h0, 8'h0, 8'h1, 8'h1};
  lbk_cpu_cfg_s cpu_cfg = {2'h2, 8'h1, 8'h2, 8'h1};
  lbk_alpha_s first_alpha_set = 12'h38F, second_alpha_set = 12'hC10;
  int bad_count, tests_run, cyc, hs_at, hs_gap, hs_hi, vs_at, vs_gap, ck_at, ck_gap;
  int den_n, den_f, req_n, req_f, mw, ms, ml, sw, s1, s2;
  int hs_len, le_n, le_f;
  lbk_top lbk_top_i (.clk, .reset_n, .timing, .cpu_cfg, .output_interface_select,
    .per_pixel_blend, .alpha_source_select, .fb_alpha_mode, .first_alpha_set,
    .second_alpha_set, .key_enable, .key_area_blend, .key_compare_direction,
    .key_compare_mask, .key_color_value, .overlay_active, .base_entry, .overlay_entry,
    .fb_alpha, .cpu_req, .cpu_reg_sel, .cpu_data, .cpu_busy, .pixel_req, .pixel_x, .pixel_y,
    .pad_clk_wr, .pad_hsync_cs0, .pad_vsync_cs1, .pad_den_rs, .pad_lend_oe, .pad_data,
    .pad_data_oe_n);
  lbk_panel_model lbk_panel_model_i (.clk, .on(output_interface_select == 2'h2),
    .cs_n(pad_hsync_cs0), .wr_n(pad_clk_wr), .rs(pad_den_rs), .data(pad_data[17:0]),
    .got(mg), .writes(mw), .setup_len(ms), .wr_len(ml));
  lbk_panel_model sub_model_i (.clk, .on(output_interface_select == 2'h3),
    .cs_n(pad_vsync_cs1), .wr_n(pad_clk_wr), .rs(pad_den_rs), .data(pad_data[17:0]),
    .got(sg), .writes(sw), .setup_len(s1), .wr_len(s2));
  initial forever #4 clk = ~clk;
  // Edge-to-edge spans of the RGB pins, sampled on the clock.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    hq <= pad_hsync_cs0;
    vq <= pad_vsync_cs1;
    cq <= pad_clk_wr;
    den_n <= den_n + pad_den_rs;
    req_n <= req_n + pixel_req;
    le_n <= le_n + pad_lend_oe;
    if (pixel_req) begin
      lx <= pixel_x;
      ly <= pixel_y;
    end
    if (!pad_hsync_cs0 && hq) hs_len <= hs_hi;
    if (pad_hsync_cs0 && !hq) begin
      hs_gap <= cyc - hs_at;
      hs_at <= cyc;
      hs_hi <= 1;
    end else if (pad_hsync_cs0) hs_hi <= hs_hi + 1;
    if (pad_clk_wr && !cq) begin
      ck_gap <= cyc - ck_at;
      ck_at <= cyc;
    end
    if (pad_vsync_cs1 && !vq) begin
      vs_gap <= cyc - vs_at;
      vs_at <= cyc;
      den_f <= den_n;
      req_f <= req_n;
      den_n <= 0;
      req_n <= 0;
      le_f <= le_n;
      le_n <= 0;
      lx_f <= lx;
      ly_f <= ly;
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] x8(input logic [4:0] c);
    return {c, c[4:2]};
  endfunction
  function automatic logic [7:0] mx(input logic [4:0] b, input logic [4:0] o, input logic [3:0] a);
    logic [11:0] s;
    s = x8(b) * (5'h10 - a) + x8(o) * a;
    return s[11:4];
  endfunction
  function automatic logic [23:0] bl(input logic [15:0] b, input logic [15:0] o,
                                     input lbk_alpha_s a);
    return {mx(b[14:10], o[14:10], a.r), mx(b[9:5], o[9:5], a.g), mx(b[4:0], o[4:0], a.b)};
  endfunction
  task meas(input logic [7:0] d);
    int ht;
    int vt;
    timing.divider = d;
    ht = timing.hsync_w + timing.hback + timing.hfront + timing.width_m1 + 4;
    vt = timing.vsync_w + timing.vback + timing.vfront + timing.height_m1 + 4;
    tick(4 * ht * vt * (d + 1));
    chk("line_period", ht * (d + 1), hs_gap);
    chk("frame_period", ht * vt * (d + 1), vs_gap);
    chk("hsync_width", (timing.hsync_w + 1) * (d + 1), hs_len);
    chk("pclk_period", d + 1, ck_gap);
    chk("den_cycles", 12 * (d + 1), den_f);
    chk("pixel_reqs", 12, req_f);
    chk("line_ends", vt * (d + 1), le_f);
    chk("last_x", timing.width_m1, lx_f);
    chk("last_y", timing.height_m1, ly_f);
  endtask
  task px(input string n, input logic [23:0] e);
    int k;
    tick(20);
    for (k = 0; k < 200 && pad_den_rs !== 1'b1; k++) tick(1);
    chk(n, e, pad_data);
  endtask
  // A second request inside the cycle must be ignored.
  task cpu_wr(input logic r, input logic [17:0] d);
    int k;
    cpu_reg_sel = r;
    cpu_data = d;
    cpu_req = 1'b1;
    for (k = 0; k < 50 && cpu_busy !== 1'b1; k++) tick(1);
    cpu_req = 1'b0;
    tick(2);
    cpu_req = 1'b1;
    tick(1);
    cpu_req = 1'b0;
    for (k = 0; k < 900 && cpu_busy !== 1'b0; k++) tick(1);
    tick(4);
  endtask
  task wrap_up();
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // The whole run needs a few thousand cycles; twenty thousand means a hang.
  initial begin
    #160000;
    bad_count++;
    wrap_up();
  end
  initial begin
    tick(5);
    reset_n = 1'b1;
    for (int d = 1; d < 3; d++) meas(d[7:0]);
    overlay_entry = OE | 16'h8000;
    px("fixed_set0", bl(BE, OE, first_alpha_set));
    alpha_source_select = 1'b1;
    px("fixed_set1", bl(BE, OE, second_alpha_set));
    per_pixel_blend = 1'b1;
    alpha_source_select = 1'b0;
    px("entry_set1", bl(BE, OE, second_alpha_set));
    overlay_entry = OE;
    px("entry_set0", bl(BE, OE, first_alpha_set));
    alpha_source_select = 1'b1;
    fb_alpha_mode = 1'b1;
    fb_alpha = 4'h9;
    px("fb_alpha", bl(BE, OE, 12'h999));
    {per_pixel_blend, alpha_source_select, fb_alpha_mode, key_enable} = 4'h1;
    key_compare_mask = 24'h070707;
    key_color_value = {x8(OE[14:10]), x8(OE[9:5]), x8(OE[4:0])} ^ 24'h010203;
    px("key_masked", {x8(BE[14:10]), x8(BE[9:5]), x8(BE[4:0])});
    key_area_blend = 1'b1;
    px("key_blend", bl(BE, OE, first_alpha_set));
    key_area_blend = 1'b0;
    key_compare_mask = 24'h0;
    px("key_miss", bl(BE, OE, first_alpha_set));
    key_compare_direction = 1'b1;
    key_color_value = {x8(BE[14:10]), x8(BE[9:5]), x8(BE[4:0])};
    px("key_base", key_color_value);
    key_enable = 1'b0;
    overlay_active = 1'b0;
    px("base_only", key_color_value);
    output_interface_select = 2'h2;
    tick(4);
    cpu_wr(1'b1, 18'h2A5C3);
    chk("main_writes", 1, mw);
    chk("main_word", {5'h0, 19'h6A5C3}, mg);
    chk("setup_len", cpu_cfg.setup + 1, ms);
    chk("wr_len", cpu_cfg.wait_t + 1, ml);
    chk("busy_idle", 24'h0, cpu_busy);
    chk("read_strobe", 24'h1, pad_lend_oe);
    output_interface_select = 2'h3;
    tick(4);
    cpu_wr(1'b0, 18'h15A3C);
    chk("sub_writes", 1, sw);
    chk("main_kept", 1, mw);
    chk("sub_word", {6'h0, 18'h15A3C}, sg);
    output_interface_select = 2'h1;
    tick(4);
    chk("rsvd_data", 24'h0, pad_data);
    chk("rsvd_oe_n", 24'h1, pad_data_oe_n);
    wrap_up();
  end
endmodule
`default_nettype wire
